// File: rtl/dtf_cmp_a.sv
/*
  Comparator A: address, bit 16, page-select and direction match.
  Assumes core bus signals come from logic on the same clock.
*/
`timescale 1ns/100ps
module dtf_cmp_a (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Core bus being watched.
  input wire logic cycle_valid,
  input wire logic [15:0] addr,
  input wire logic linear_valid,
  input wire logic [16:0] linear_addr,
  input wire logic [2:0] prog_page,
  input wire logic page_sel,
  input wire logic read_cycle,
  // Compare settings.
  input wire logic [7:0] cmp_hi,
  input wire logic [7:0] cmp_lo,
  input wire logic dir_en,
  input wire logic dir_val,
  input wire logic page_q,
  input wire logic bit16,
  // Result.
  output logic match
);
  import dtf_pkg::*;

  logic [DTF_CORE_AW-1:0] core_addr;
  logic addr_ok;
  logic b16_ok;
  logic page_ok;
  logic dir_ok;
  logic match_reg;

  // Paged program access, or plain/linear access with page-select low.
  assign core_addr = page_sel ?
    {prog_page, addr[DTF_PAGED_OFS_W-1:0]} :
    (linear_valid ? linear_addr : {1'b0, addr});
  assign addr_ok = (core_addr[15:0] == {cmp_hi, cmp_lo});
  assign b16_ok = (core_addr[DTF_CORE_AW-1] == bit16);
  assign page_ok = (page_sel == page_q);
  assign dir_ok = ~dir_en | (read_cycle == dir_val);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      match_reg <= 1'b0;
    else
      match_reg <= cycle_valid & addr_ok & b16_ok & page_ok & dir_ok;
  end

  assign match = match_reg;

endmodule // dtf_cmp_a

// File: rtl/dtf_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and a flush input.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
module dtf_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flush,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level.
  output logic [$clog2(DEPTH+1)-1:0] count
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
    $error("dtf_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != CW'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push = in_valid & in_ready & ~flush;
  assign pop = out_valid & out_ready & ~flush;
  assign out_data = mem[rd_ptr_reg];
  assign count = count_reg;

  always_ff @(posedge clk) begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + PW'(push);
      rd_ptr_reg <= rd_ptr_reg + PW'(pop);
      count_reg <= count_reg + CW'(push) - CW'(pop);
    end
  end

endmodule // dtf_fifo

// File: rtl/dtf_pkg.sv
/*
  Constants shared by the debug trace FIFO and comparator A block.
  Assumes a 32-bit APB register bus with word-aligned registers.
*/
package dtf_pkg;

  // APB geometry.
  localparam int DTF_DATA_W = 32;
  localparam int DTF_ADDR_W = 12;
  localparam int DTF_IDX_W = 10;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] DTF_IDX_CMPA_HI = 10'h000;
  localparam logic [9:0] DTF_IDX_CMPA_LO = 10'h001;
  localparam logic [9:0] DTF_IDX_FIFO_HI = 10'h006;
  localparam logic [9:0] DTF_IDX_FIFO_LO = 10'h007;
  localparam logic [9:0] DTF_IDX_CMPA_EXT = 10'h008;
  localparam logic [9:0] DTF_IDX_FIFO_EXT = 10'h00C;
  localparam logic [9:0] DTF_IDX_CONFIG = 10'h010;
  localparam logic [9:0] DTF_IDX_STATUS = 10'h011;

  // Comparator A extension fields.
  localparam int DTF_EXT_DIR_EN_BIT = 7;
  localparam int DTF_EXT_DIR_VAL_BIT = 6;
  localparam int DTF_EXT_PAGE_BIT = 5;
  localparam int DTF_EXT_B16_BIT = 0;
  localparam logic [7:0] DTF_EXT_WMASK = 8'hE1;

  // Configuration fields.
  localparam int DTF_CFG_EN_BIT = 0;
  localparam int DTF_CFG_BEGIN_BIT = 1;
  localparam int DTF_CFG_EVONLY_BIT = 2;
  localparam logic [7:0] DTF_CFG_WMASK = 8'h07;

  // Status fields.
  localparam int DTF_STAT_EMPTY_BIT = 0;
  localparam int DTF_STAT_ORDER_BIT = 1;
  localparam int DTF_STAT_CNT_LSB = 8;

  // Trace word layout: extension byte above the 16 data bits.
  localparam int DTF_FIFO_WIDTH = 24;
  localparam int DTF_FIFO_DEPTH = 32;
  localparam int DTF_LO_LSB = 0;
  localparam int DTF_HI_LSB = 8;
  localparam int DTF_EXT_LSB = 16;

  // Address layout of the compared 17-bit core address.
  localparam int DTF_CORE_AW = 17;
  localparam int DTF_PAGE_W = 3;
  localparam int DTF_PAGED_OFS_W = 14;

  // Reset values.
  localparam logic [7:0] DTF_BYTE_RST = 8'h00;
  localparam logic [31:0] DTF_WORD_ZERO = 32'h0000_0000;

endpackage

// File: rtl/dtf_top.sv
/*
  Debug trace FIFO read path and comparator A extension registers,
  reached over APB. Assumes the capture logic delivers trace words on
  the same clock, and that chip reset requests arrive as a one-cycle
  pulse together with their cause.

*/
`timescale 1ns/100ps
module dtf_top #(
  parameter int FIFO_DEPTH = dtf_pkg::DTF_FIFO_DEPTH,
  parameter int FIFO_WIDTH = dtf_pkg::DTF_FIFO_WIDTH
) (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RST_B,
  // Chip reset request and its cause.
  input wire logic CHIP_RESET,
  input wire logic RESET_CAUSE_END_TRACE,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [dtf_pkg::DTF_ADDR_W-1:0] PADDR,
  input wire logic [dtf_pkg::DTF_DATA_W-1:0] PWDATA,
  output logic [dtf_pkg::DTF_DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Trace words from the capture logic.
  input wire logic TRACE_VALID,
  input wire logic [dtf_pkg::DTF_FIFO_WIDTH-1:0] TRACE_WORD,
  output logic TRACE_READY,
  // Watched core bus.
  input wire logic CORE_CYCLE_VALID,
  input wire logic [15:0] CORE_ADDR,
  input wire logic CORE_LINEAR_VALID,
  input wire logic [16:0] CORE_LINEAR_ADDR,
  input wire logic [2:0] CORE_PROG_PAGE,
  input wire logic CORE_PAGE_SEL,
  input wire logic CORE_READ,
  // Comparator A result and debug state.
  output logic CMP_A_MATCH,
  output logic DEBUG_MODULE_ENABLE,
  output logic TRACE_BEGIN,
  output logic EVENT_ONLY_MODE
);
  import dtf_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH+1);

  // Refuse a layout or a depth that the status word cannot report.
  if (FIFO_WIDTH != DTF_FIFO_WIDTH) begin : g_bad_width
    $error("dtf_top: FIFO_WIDTH must match the trace word layout");
  end
  if (FIFO_DEPTH < 2 || CW > DTF_DATA_W - DTF_STAT_CNT_LSB) begin : g_bad_depth
    $error("dtf_top: FIFO_DEPTH out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode.

  logic [DTF_IDX_W-1:0] idx;
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic rd_access;
  logic hit_cmpa_hi;
  logic hit_cmpa_lo;
  logic hit_fifo_hi;
  logic hit_fifo_lo;
  logic hit_cmpa_ext;
  logic hit_fifo_ext;
  logic hit_config;
  logic hit_status;
  logic mapped;
  logic aligned;

  assign idx = PADDR[DTF_ADDR_W-1:2];
  assign aligned = (PADDR[1:0] == 2'h0);
  assign setup_phase = PSEL & ~PENABLE;
  assign access_phase = PSEL & PENABLE;
  assign wr_access = access_phase & PWRITE;
  assign rd_access = access_phase & ~PWRITE;

  // Compares one register index; an unaligned address hits nothing.
  function automatic logic reg_hit(
    input logic [DTF_IDX_W-1:0] at,
    input logic ok,
    input logic [DTF_IDX_W-1:0] want
  );
    return ok & (at == want);
  endfunction

  assign hit_cmpa_hi = reg_hit(idx, aligned, DTF_IDX_CMPA_HI);
  assign hit_cmpa_lo = reg_hit(idx, aligned, DTF_IDX_CMPA_LO);
  assign hit_fifo_hi = reg_hit(idx, aligned, DTF_IDX_FIFO_HI);
  assign hit_fifo_lo = reg_hit(idx, aligned, DTF_IDX_FIFO_LO);
  assign hit_cmpa_ext = reg_hit(idx, aligned, DTF_IDX_CMPA_EXT);
  assign hit_fifo_ext = reg_hit(idx, aligned, DTF_IDX_FIFO_EXT);
  assign hit_config = reg_hit(idx, aligned, DTF_IDX_CONFIG);
  assign hit_status = reg_hit(idx, aligned, DTF_IDX_STATUS);

  assign mapped = hit_cmpa_hi | hit_cmpa_lo | hit_fifo_hi | hit_fifo_lo |
    hit_cmpa_ext | hit_fifo_ext | hit_config | hit_status;

  // Zero wait states; read data was captured in the setup cycle.
  assign PREADY = 1'b1;
  // Only the access phase flags an error, so a setup cycle never does.
  assign PSLVERR = access_phase & ~mapped;

  ////////////////////////////////////////////////////////////////////////
  // Reset retention.

  logic [7:0] cfg_reg;
  logic keep_state;
  logic soft_clear;

  // An end-trace reset with debug on and begin-trigger off keeps state.
  assign keep_state = RESET_CAUSE_END_TRACE & cfg_reg[DTF_CFG_EN_BIT] &
    ~cfg_reg[DTF_CFG_BEGIN_BIT];
  // A clear outranks any write that falls in the same cycle.
  assign soft_clear = CHIP_RESET & ~keep_state;

  ////////////////////////////////////////////////////////////////////////
  // Software-written registers.

  logic [7:0] cmpa_hi_reg;
  logic [7:0] cmpa_hi_next;
  logic [7:0] cmpa_lo_reg;
  logic [7:0] cmpa_lo_next;
  logic [7:0] cmpa_ext_reg;
  logic [7:0] cmpa_ext_next;
  logic [7:0] cfg_next;
  logic [7:0] wbyte;

  // Writes to the read-only trace registers leave every register unchanged.
  assign wbyte = PWDATA[7:0];
  assign cmpa_hi_next = (wr_access & hit_cmpa_hi) ? wbyte : cmpa_hi_reg;
  assign cmpa_lo_next = (wr_access & hit_cmpa_lo) ? wbyte : cmpa_lo_reg;
  // Bits 4 to 1 of the extension register are reserved and stay zero.
  assign cmpa_ext_next = (wr_access & hit_cmpa_ext) ?
    (wbyte & DTF_EXT_WMASK) : cmpa_ext_reg;
  assign cfg_next = (wr_access & hit_config) ?
    (wbyte & DTF_CFG_WMASK) : cfg_reg;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      cmpa_hi_reg <= DTF_BYTE_RST;
      cmpa_lo_reg <= DTF_BYTE_RST;
      cmpa_ext_reg <= DTF_BYTE_RST;
      cfg_reg <= DTF_BYTE_RST;
    end else if (soft_clear) begin
      cmpa_hi_reg <= DTF_BYTE_RST;
      cmpa_lo_reg <= DTF_BYTE_RST;
      cmpa_ext_reg <= DTF_BYTE_RST;
      cfg_reg <= DTF_BYTE_RST;
    end else begin
      cmpa_hi_reg <= cmpa_hi_next;
      cmpa_lo_reg <= cmpa_lo_next;
      cmpa_ext_reg <= cmpa_ext_next;
      cfg_reg <= cfg_next;
    end
  end

  assign DEBUG_MODULE_ENABLE = cfg_reg[DTF_CFG_EN_BIT];
  assign TRACE_BEGIN = cfg_reg[DTF_CFG_BEGIN_BIT];
  assign EVENT_ONLY_MODE = cfg_reg[DTF_CFG_EVONLY_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Trace FIFO and its read path.

  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [FIFO_WIDTH-1:0] fifo_head;
  logic [CW-1:0] fifo_count;
  logic event_only;
  logic [7:0] head_lo;
  logic [7:0] head_hi;
  logic [7:0] head_ext;

  assign event_only = cfg_reg[DTF_CFG_EVONLY_BIT];
  assign fifo_in_valid = TRACE_VALID & cfg_reg[DTF_CFG_EN_BIT];
  assign TRACE_READY = fifo_in_ready & cfg_reg[DTF_CFG_EN_BIT];

  // Only a completed low-byte read moves the FIFO on.
  assign fifo_pop = rd_access & hit_fifo_lo;

  dtf_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) dtf_fifo_i (
    .clk(CLOCK),
    .rst_b(RST_B),
    .flush(soft_clear),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(TRACE_WORD),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_head),
    .count(fifo_count)
  );

  // Picks one byte of the head word, or zero where it must not show.
  function automatic logic [7:0] head_byte(
    input logic [FIFO_WIDTH-1:0] word,
    input int lsb,
    input logic show
  );
    return show ? word[lsb+:8] : DTF_BYTE_RST;
  endfunction

  assign head_lo = head_byte(fifo_head, DTF_LO_LSB, fifo_out_valid);
  assign head_hi = head_byte(fifo_head, DTF_HI_LSB,
    fifo_out_valid & ~event_only);
  // The extension byte is as empty as the high byte in event-only mode.
  assign head_ext = head_byte(fifo_head, DTF_EXT_LSB,
    fifo_out_valid & ~event_only);

  ////////////////////////////////////////////////////////////////////////
  // Read order watch.

  logic ext_seen_reg;
  logic ext_seen_next;
  logic hi_seen_reg;
  logic hi_seen_next;
  logic order_fault_reg;
  logic order_fault_next;
  logic order_bad;
  logic order_clr;

  // A full-mode word read without extension and high first is flagged.
  assign order_bad = fifo_pop & fifo_out_valid & ~event_only &
    ~(ext_seen_reg & hi_seen_reg);
  assign order_clr = wr_access & hit_status & PWDATA[DTF_STAT_ORDER_BIT];
  // The seen flags restart at every pop, so each word is judged alone.
  assign ext_seen_next = fifo_pop ? 1'b0 :
    ((rd_access & hit_fifo_ext) | ext_seen_reg);
  assign hi_seen_next = fifo_pop ? 1'b0 :
    ((rd_access & hit_fifo_hi & ext_seen_reg) | hi_seen_reg);
  // A new fault in the clearing cycle stays set.
  assign order_fault_next = order_bad | (order_fault_reg & ~order_clr);

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ext_seen_reg <= 1'b0;
      hi_seen_reg <= 1'b0;
      order_fault_reg <= 1'b0;
    end else if (soft_clear) begin
      ext_seen_reg <= 1'b0;
      hi_seen_reg <= 1'b0;
      order_fault_reg <= 1'b0;
    end else begin
      ext_seen_reg <= ext_seen_next;
      hi_seen_reg <= hi_seen_next;
      order_fault_reg <= order_fault_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparator A.

  // The match is registered, so it trails the watched cycle by one clock.
  dtf_cmp_a dtf_cmp_a_i (
    .clk(CLOCK),
    .rst_b(RST_B),
    .cycle_valid(CORE_CYCLE_VALID),
    .addr(CORE_ADDR),
    .linear_valid(CORE_LINEAR_VALID),
    .linear_addr(CORE_LINEAR_ADDR),
    .prog_page(CORE_PROG_PAGE),
    .page_sel(CORE_PAGE_SEL),
    .read_cycle(CORE_READ),
    .cmp_hi(cmpa_hi_reg),
    .cmp_lo(cmpa_lo_reg),
    .dir_en(cmpa_ext_reg[DTF_EXT_DIR_EN_BIT]),
    .dir_val(cmpa_ext_reg[DTF_EXT_DIR_VAL_BIT]),
    .page_q(cmpa_ext_reg[DTF_EXT_PAGE_BIT]),
    .bit16(cmpa_ext_reg[DTF_EXT_B16_BIT]),
    .match(CMP_A_MATCH)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read data.

  logic [DTF_DATA_W-1:0] status_word;
  logic [DTF_DATA_W-1:0] rd_mux;
  logic [DTF_DATA_W-1:0] prdata_reg;
  logic [DTF_DATA_W-1:0] prdata_next;

  function automatic logic [DTF_DATA_W-1:0] byte_word(
    input logic [7:0] b
  );
    return {24'h00_0000, b};
  endfunction

  // The count sits above the flags so one read returns both.
  always_comb begin
    status_word = DTF_WORD_ZERO;
    status_word[DTF_STAT_EMPTY_BIT] = ~fifo_out_valid;
    status_word[DTF_STAT_ORDER_BIT] = order_fault_reg;
    status_word[DTF_STAT_CNT_LSB+:CW] = fifo_count;
  end

  assign rd_mux =
    hit_cmpa_hi ? byte_word(cmpa_hi_reg) :
    hit_cmpa_lo ? byte_word(cmpa_lo_reg) :
    hit_fifo_hi ? byte_word(head_hi) :
    hit_fifo_lo ? byte_word(head_lo) :
    hit_cmpa_ext ? byte_word(cmpa_ext_reg) :
    hit_fifo_ext ? byte_word(head_ext) :
    hit_config ? byte_word(cfg_reg) :
    hit_status ? status_word :
    DTF_WORD_ZERO;

  // Captured in the setup cycle so the access phase sees a stable word.
  assign prdata_next = (setup_phase & ~PWRITE) ? rd_mux : prdata_reg;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B)
      prdata_reg <= DTF_WORD_ZERO;
    else
      prdata_reg <= prdata_next;
  end

  assign PRDATA = prdata_reg;

endmodule // dtf_top

// File: verif/dtf_chk.sv
/*
  Concurrent checks on the ports of the debug trace block top.
  Assumes it is bound to dtf_top and sees only that module's ports.
*/
`timescale 1ns/100ps
module dtf_chk (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RST_B,
  // Chip reset request.
  input wire logic CHIP_RESET,
  input wire logic RESET_CAUSE_END_TRACE,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [dtf_pkg::DTF_ADDR_W-1:0] PADDR,
  input wire logic [dtf_pkg::DTF_DATA_W-1:0] PWDATA,
  input wire logic [dtf_pkg::DTF_DATA_W-1:0] PRDATA,
  input wire logic PSLVERR,
  // Trace, compare and debug state.
  input wire logic TRACE_READY,
  input wire logic CORE_CYCLE_VALID,
  input wire logic CMP_A_MATCH,
  input wire logic DEBUG_MODULE_ENABLE,
  input wire logic TRACE_BEGIN,
  input wire logic EVENT_ONLY_MODE
);
  import dtf_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  logic [2:0] wdata_reg;
  wire rd_setup = PSEL && !PENABLE && !PWRITE;
  wire keep_cond = RESET_CAUSE_END_TRACE && DEBUG_MODULE_ENABLE && !TRACE_BEGIN;
  always_ff @(posedge CLOCK) begin
    wdata_reg <= PWDATA[2:0];
  end
  ////////////////////////////////////////
  sequence s_rd(logic [11:0] a);
    rd_setup && PADDR == a;
  endsequence
  sequence s_cfg_wr;
    PSEL && PENABLE && PWRITE && PADDR == {DTF_IDX_CONFIG, 2'b00} && !CHIP_RESET;
  endsequence
  AST_HI_EVONLY: assert property (s_rd({DTF_IDX_FIFO_HI, 2'b00}) ##0 EVENT_ONLY_MODE
    |=> PRDATA == DTF_WORD_ZERO) else $error("high byte not zero in event-only mode");
  AST_LO_BYTE: assert property (s_rd({DTF_IDX_FIFO_LO, 2'b00})
    |=> PRDATA[31:8] == 24'h00_0000) else $error("low byte read wider than a byte");
  AST_EXT_RSV: assert property (s_rd({DTF_IDX_CMPA_EXT, 2'b00})
    |=> (PRDATA & ~32'h0000_00E1) == DTF_WORD_ZERO) else $error("extension reserved bits set");
  AST_MATCH_CAUSE: assert property (CMP_A_MATCH |-> $past(CORE_CYCLE_VALID))
    else $error("match without a core cycle");
  AST_CLEAR: assert property (CHIP_RESET && !keep_cond
    |=> !DEBUG_MODULE_ENABLE && !TRACE_BEGIN && !EVENT_ONLY_MODE) else $error("reset kept state");
  AST_KEEP: assert property (CHIP_RESET && keep_cond && !PSEL
    |=> $stable({DEBUG_MODULE_ENABLE, EVENT_ONLY_MODE})) else $error("end-trace reset lost state");
  AST_CFG_WR: assert property (s_cfg_wr
    |=> {EVENT_ONLY_MODE, TRACE_BEGIN, DEBUG_MODULE_ENABLE} == wdata_reg)
    else $error("config write not taken");
  AST_READY_GATE: assert property (TRACE_READY |-> DEBUG_MODULE_ENABLE)
    else $error("trace accepted while disabled");
  AST_ALIGN_ERR: assert property (PSEL && PENABLE && PADDR[1:0] != 2'b00 |-> PSLVERR)
    else $error("unaligned access without error");
  AST_RD_HOLD: assert property (!rd_setup && !CHIP_RESET |=> $stable(PRDATA))
    else $error("read data moved without a read");
endmodule // dtf_chk
bind dtf_top dtf_chk dtf_chk_i (.CLOCK(CLOCK), .RST_B(RST_B), .CHIP_RESET(CHIP_RESET),
  .RESET_CAUSE_END_TRACE(RESET_CAUSE_END_TRACE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .TRACE_READY(TRACE_READY), .CORE_CYCLE_VALID(CORE_CYCLE_VALID), .CMP_A_MATCH(CMP_A_MATCH),
  .DEBUG_MODULE_ENABLE(DEBUG_MODULE_ENABLE), .TRACE_BEGIN(TRACE_BEGIN),
  .EVENT_ONLY_MODE(EVENT_ONLY_MODE));

// File: verif/dtf_core_model.sv
/*
  Far-side model: the capture logic that offers trace words.
  Assumes the bench queues words through push between clock edges.
*/
`timescale 1ns/100ps
module dtf_core_model (
  // Clock.
  input wire logic clk,
  // Trace word handshake.
  input wire logic trace_ready,
  output logic trace_valid,
  output logic [23:0] trace_word
);
  logic [23:0] mem [64];
  int wr_n = 0;
  int rd_n = 0;
  initial begin
    trace_valid = 1'b0;
    trace_word = 24'h00_0000;
  end
  task automatic push(input logic [23:0] w);
    mem[wr_n] = w;
    wr_n++;
  endtask
  ////////////////////////////////////////
  // A word stands until taken; an idle line flips between the last word and its inverse on each clock.
  always @(posedge clk) begin
    if (trace_valid && trace_ready) begin
      rd_n = rd_n + 1;
    end
    trace_valid <= (rd_n != wr_n);
    trace_word <= (rd_n != wr_n) ? mem[rd_n] : ~trace_word;
  end
endmodule // dtf_core_model

// File: verif/dtf_top_tb_top.sv
/*
  Bench for the debug trace block: registers over APB, FIFO fill and
  drain, chip reset retention and comparator A. Assumes dtf_core_model
  supplies trace words and the bench drives the watched core bus.
*/
`timescale 1ns/100ps
module dtf_top_tb_top;
  import dtf_pkg::*;
  typedef struct packed {
    logic [7:0] ext;
    logic [15:0] a;
    logic lv;
    logic [16:0] la;
    logic ps;
    logic [2:0] pg;
    logic rd;
    logic m;
  } dtf_case_type;
  localparam logic [11:0] A_HI = {DTF_IDX_FIFO_HI, 2'b00};
  localparam logic [11:0] A_LO = {DTF_IDX_FIFO_LO, 2'b00};
  localparam logic [11:0] A_FX = {DTF_IDX_FIFO_EXT, 2'b00};
  localparam logic [11:0] A_EXT = {DTF_IDX_CMPA_EXT, 2'b00};
  localparam logic [11:0] A_CFG = {DTF_IDX_CONFIG, 2'b00};
  localparam logic [11:0] A_ST = {DTF_IDX_STATUS, 2'b00};
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic chip_reset = 1'b0;
  logic cause = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tr_valid;
  logic [23:0] tr_word;
  logic tr_ready;
  logic cv = 1'b0;
  logic [15:0] ca = 16'h0000;
  logic clv = 1'b0;
  logic [16:0] cla = 17'h0_0000;
  logic [2:0] cpg = 3'h0;
  logic cps = 1'b0;
  logic crd = 1'b0;
  logic match;
  logic [31:0] r;
  logic err_seen;
  logic [23:0] w;
  int miscompares = 0;
  int n_tests = 0;
  dtf_case_type cases [11];
  logic [11:0] zr [7];
  initial begin
    forever #20 clock = ~clock;
  end
  dtf_top #(.FIFO_DEPTH(32), .FIFO_WIDTH(24)) dtf_top_i (.CLOCK(clock), .RST_B(rst_b),
    .CHIP_RESET(chip_reset), .RESET_CAUSE_END_TRACE(cause), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TRACE_VALID(tr_valid), .TRACE_WORD(tr_word), .TRACE_READY(tr_ready),
    .CORE_CYCLE_VALID(cv), .CORE_ADDR(ca), .CORE_LINEAR_VALID(clv), .CORE_LINEAR_ADDR(cla),
    .CORE_PROG_PAGE(cpg), .CORE_PAGE_SEL(cps), .CORE_READ(crd), .CMP_A_MATCH(match),
    .DEBUG_MODULE_ENABLE(), .TRACE_BEGIN(), .EVENT_ONLY_MODE());
  dtf_core_model dtf_core_model_i (.clk(clock), .trace_ready(tr_ready),
    .trace_valid(tr_valid), .trace_word(tr_word));
  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    if (pready !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Waits until an edge passes with no word taken from the model.
  task automatic settle();
    int n;
    repeat (2) @(posedge clock);
    n = 0;
    while (tr_valid && tr_ready && n < 100) begin
      @(posedge clock);
      n++;
    end
    if (n >= 100) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic creset(input logic c);
    chip_reset <= 1'b1;
    cause <= c;
    @(posedge clock);
    chip_reset <= 1'b0;
    @(posedge clock);
  endtask
  task automatic core(input dtf_case_type t);
    wr(A_EXT, {24'h00_0000, t.ext});
    cv <= 1'b1;
    ca <= t.a;
    clv <= t.lv;
    cla <= t.la;
    cps <= t.ps;
    cpg <= t.pg;
    crd <= t.rd;
    @(posedge clock);
    cv <= 1'b0;
    ca <= ~t.a;
    #1;
    chk(match, t.m);
    @(posedge clock);
  endtask
  function automatic logic [23:0] wd(input int i);
    logic [7:0] b;
    b = i[7:0];
    return {b + 8'h40, ~b, b};
  endfunction
  ////////////////////////////////////////
  initial begin
    zr = '{12'h000, 12'h004, A_HI, A_LO, A_EXT, A_FX, A_CFG};
    cases = '{'{8'h00, 16'h1234, 1'b0, 17'h0_0000, 1'b0, 3'h0, 1'b1, 1'b1},
      '{8'h00, 16'h1235, 1'b0, 17'h0_0000, 1'b0, 3'h0, 1'b1, 1'b0},
      '{8'h80, 16'h1234, 1'b0, 17'h0_0000, 1'b0, 3'h0, 1'b1, 1'b0},
      '{8'h80, 16'h1234, 1'b0, 17'h0_0000, 1'b0, 3'h0, 1'b0, 1'b1},
      '{8'hC0, 16'h1234, 1'b0, 17'h0_0000, 1'b0, 3'h0, 1'b1, 1'b1},
      '{8'h40, 16'h1234, 1'b0, 17'h0_0000, 1'b0, 3'h0, 1'b0, 1'b1},
      '{8'h21, 16'hD234, 1'b0, 17'h0_0000, 1'b1, 3'h4, 1'b1, 1'b1},
      '{8'h21, 16'h1234, 1'b0, 17'h0_0000, 1'b0, 3'h4, 1'b1, 1'b0},
      '{8'h01, 16'h0000, 1'b1, 17'h1_1234, 1'b0, 3'h0, 1'b1, 1'b1},
      '{8'h00, 16'h1234, 1'b1, 17'h1_1234, 1'b0, 3'h0, 1'b1, 1'b0},
      '{8'h21, 16'hD234, 1'b0, 17'h0_0000, 1'b1, 3'h0, 1'b1, 1'b0}};
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    foreach (zr[i]) rd(zr[i], 32'h0000_0000);
    rd(A_ST, 32'h0000_0001);
    chk(err_seen, 1'b0);
    rd(12'h050, 32'h0000_0000);
    chk(err_seen, 1'b1);
    rd(12'h01E, 32'h0000_0000);
    chk(err_seen, 1'b1);
    wr(A_EXT, 32'h0000_00FF);
    rd(A_EXT, 32'h0000_00E1);
    wr(12'h000, 32'h0000_0012);
    wr(12'h004, 32'h0000_0034);
    foreach (cases[i]) begin
      core(cases[i]);
    end
    wr(A_CFG, 32'h0000_0001);
    for (int i = 0; i < 33; i++) dtf_core_model_i.push(wd(i));
    settle();
    chk(tr_ready, 1'b0);
    rd(A_ST, 32'h0000_2000);
    wr(A_LO, 32'h0000_00FF);
    w = wd(0);
    rd(A_FX, w[23:16]);
    rd(A_HI, w[15:8]);
    rd(A_LO, w[7:0]);
    rd(A_ST, 32'h0000_2000);
    for (int i = 1; i < 33; i++) begin
      w = wd(i);
      rd(A_LO, w[7:0]);
    end
    rd(A_ST, 32'h0000_0003);
    rd(A_LO, 32'h0000_0000);
    wr(A_ST, 32'h0000_0002);
    rd(A_ST, 32'h0000_0001);
    wr(A_CFG, 32'h0000_0005);
    dtf_core_model_i.push(24'h12_3456);
    settle();
    rd(A_HI, 32'h0000_0000);
    rd(A_FX, 32'h0000_0000);
    rd(A_LO, 32'h0000_0056);
    rd(A_ST, 32'h0000_0001);
    wr(A_EXT, 32'h0000_00A1);
    wr(A_CFG, 32'h0000_0001);
    creset(1'b1);
    rd(A_EXT, 32'h0000_00A1);
    rd(A_CFG, 32'h0000_0001);
    creset(1'b0);
    rd(A_EXT, 32'h0000_0000);
    rd(A_CFG, 32'h0000_0000);
    wr(A_EXT, 32'h0000_00A1);
    wr(A_CFG, 32'h0000_0003);
    creset(1'b1);
    rd(A_EXT, 32'h0000_0000);
    wr(A_EXT, 32'h0000_00A1);
    rst_b <= 1'b0;
    @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rd(A_EXT, 32'h0000_0000);
    tally_and_finish();
  end
endmodule // dtf_top_tb_top
